/* logic/gad_aux_cmd_decoder.sv */
// Purpose: auxiliary command port, decodes pulsed and static commands
// Assumes: Avalon-MM master, status inputs from same-clock logic
// Notes: write-only command byte at one word, flags readable at next
//
// The implementer's own choices: the Avalon-MM register port and the placing of the registers.
module gad_aux_cmd_decoder (
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic byte_received_in,
    input wire logic end_condition_in,
    input wire logic dac_holdoff_req_in,
    input wire logic address_pass_through_in,
    output logic [gad_pkg::NUM_FLAGS-1:0] feature_flags_out,
    output logic [gad_pkg::NUM_PULSES-1:0] cmd_pulse_out,
    output logic iface_idle_out,
    output logic bus_present_out,
    output logic rfd_holdoff_out,
    output logic dac_holdoff_out,
    output logic secondary_valid_out,
    output logic secondary_invalid_out,
    output logic rtl_message_out,
    output logic interrupt_disable_out,
    output logic trigger_output_pin_out
);

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    // whole-byte compare keeps bits 6..5 significant, so any byte
    // with them set matches nothing and is dropped
    function automatic logic aux_hit(input logic acc,
                                     input logic [7:0] b,
                                     input logic [7:0] code);
        return acc && (b == code) &&
               ((b & gad_pkg::RSVD_BIT_MASK) == 8'h00);
    endfunction

    function automatic logic [7:0] set_code(input logic [7:0] clr);
        return clr | gad_pkg::SET_BIT_MASK;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic wait_reg;
    logic [2:0] gap_reg;
    logic [31:0] rdata_reg;
    logic [gad_pkg::NUM_FLAGS-1:0] flags_reg;
    logic [gad_pkg::NUM_PULSES-1:0] pulse_reg;
    logic present_reg;
    logic rfd_reg;
    logic dac_reg;
    logic sec_valid_reg;
    logic sec_invalid_reg;
    logic rtl_msg_reg;
    logic fget_clr_reg;

    logic wr_acc;
    logic aux_acc;
    logic [7:0] cmd;
    logic chip_rst;
    logic swrst_cmd;
    logic rel_dac;
    logic rel_rfd;
    logic [31:0] read_mux;
    logic [31:0] status_word;

    gad_trig_if trig ();

    assign wr_acc = avs_write_in & ~wait_reg;
    assign aux_acc = wr_acc & (avs_address_in == gad_pkg::OFS_AUX_CMD) &
                     avs_byteenable_in[0];
    assign cmd = avs_writedata_in[7:0];
    assign chip_rst = aux_hit(aux_acc, cmd,
                              gad_pkg::PULSE_CODE[gad_pkg::P_CHRST]);
    assign swrst_cmd = aux_hit(aux_acc, cmd,
        set_code(gad_pkg::FLAG_CLR_CODE[gad_pkg::FL_SWRST]));
    assign rel_dac =
        aux_hit(aux_acc, cmd, gad_pkg::PULSE_CODE[gad_pkg::P_NONVALID]) |
        aux_hit(aux_acc, cmd, gad_pkg::PULSE_CODE[gad_pkg::P_VALID]);
    assign rel_rfd =
        aux_hit(aux_acc, cmd, gad_pkg::PULSE_CODE[gad_pkg::P_RHDF]);

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    // waitrequest rests high and drops for exactly one cycle per
    // request; writes are held off until the spacing gap has run out
    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            wait_reg <= 1'b1;
        else if (!wait_reg)
            wait_reg <= 1'b1;
        else if (avs_read_in || (avs_write_in && gap_reg == 3'h0))
            wait_reg <= 1'b0;
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            gap_reg <= 3'h0;
        else if (wr_acc)
            gap_reg <= gad_pkg::GAP_LOAD;
        else if (gap_reg != 3'h0)
            gap_reg <= gap_reg - 3'h1;
    end

    assign status_word = {13'h0000, trig.pin, dac_reg, rfd_reg, flags_reg};

    always_comb
    begin
        read_mux = gad_pkg::READ_ZERO;
        if (avs_address_in == gad_pkg::OFS_STATUS)
            read_mux = status_word;
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            rdata_reg <= gad_pkg::READ_ZERO;
        else if (wait_reg && avs_read_in)
            rdata_reg <= read_mux;
    end

    // ------------------------------------------------------------
    // static feature flags
    // ------------------------------------------------------------
    // chip reset reloads the reset pattern: software reset set, the
    // holdoff, trigger and return-to-local features all cleared
    for (genvar i = 0; i < gad_pkg::NUM_FLAGS; i++)
    begin : g_flag
        localparam logic [7:0] CLR_C = gad_pkg::FLAG_CLR_CODE[i];
        always_ff @(posedge ref_clk_in or negedge arst_n_in)
        begin
            if (!arst_n_in)
                flags_reg[i] <= gad_pkg::FLAGS_RESET[i];
            else if (chip_rst)
                flags_reg[i] <= gad_pkg::FLAGS_RESET[i];
            else if (aux_hit(aux_acc, cmd, set_code(CLR_C)))
                flags_reg[i] <= 1'b1;
            else if (aux_hit(aux_acc, cmd, CLR_C))
                flags_reg[i] <= 1'b0;
            else if ((i == gad_pkg::FL_LON || i == gad_pkg::FL_TON) &&
                     swrst_cmd)
                flags_reg[i] <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // pulsed commands
    // ------------------------------------------------------------
    // one-hot for the cycle after the accepting edge; reserved
    // codes match no entry and leave everything alone
    for (genvar j = 0; j < gad_pkg::NUM_PULSES; j++)
    begin : g_pulse
        always_ff @(posedge ref_clk_in or negedge arst_n_in)
        begin
            if (!arst_n_in)
                pulse_reg[j] <= 1'b0;
            else
                pulse_reg[j] <= aux_hit(aux_acc, cmd,
                    gad_pkg::PULSE_CODE[j]);
        end
    end

    // ------------------------------------------------------------
    // presence and holdoffs
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            present_reg <= 1'b0;
        else
            present_reg <= ~flags_reg[gad_pkg::FL_SWRST];
    end

    // set wins over the release so a byte landing with the release
    // command is still held off
    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            rfd_reg <= 1'b0;
        else if (byte_received_in && !flags_reg[gad_pkg::FL_SWRST] &&
                 (flags_reg[gad_pkg::FL_HDFA] ||
                  (flags_reg[gad_pkg::FL_HDFE] && end_condition_in)))
            rfd_reg <= 1'b1;
        else if (rel_rfd || flags_reg[gad_pkg::FL_SWRST])
            rfd_reg <= 1'b0;
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            dac_reg <= 1'b0;
        else if (dac_holdoff_req_in && !flags_reg[gad_pkg::FL_SWRST])
            dac_reg <= 1'b1;
        else if (rel_dac || flags_reg[gad_pkg::FL_SWRST])
            dac_reg <= 1'b0;
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            sec_valid_reg <= 1'b0;
            sec_invalid_reg <= 1'b0;
        end
        else
        begin
            sec_valid_reg <= address_pass_through_in && aux_hit(aux_acc,
                cmd, gad_pkg::PULSE_CODE[gad_pkg::P_VALID]);
            sec_invalid_reg <= address_pass_through_in && aux_hit(aux_acc,
                cmd, gad_pkg::PULSE_CODE[gad_pkg::P_NONVALID]);
        end
    end

    // ------------------------------------------------------------
    // return-to-local message and trigger
    // ------------------------------------------------------------
    // clearing return-to-local still shows the message for one cycle
    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            rtl_msg_reg <= 1'b0;
        else if (chip_rst)
            rtl_msg_reg <= 1'b0;
        else if (aux_hit(aux_acc, cmd,
                         gad_pkg::FLAG_CLR_CODE[gad_pkg::FL_RTL]))
            rtl_msg_reg <= 1'b1;
        else if (aux_hit(aux_acc, cmd,
                 set_code(gad_pkg::FLAG_CLR_CODE[gad_pkg::FL_RTL])))
            rtl_msg_reg <= 1'b1;
        else
            rtl_msg_reg <= flags_reg[gad_pkg::FL_RTL];
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            fget_clr_reg <= 1'b0;
        else
            fget_clr_reg <= aux_hit(aux_acc, cmd,
                gad_pkg::FLAG_CLR_CODE[gad_pkg::FL_FGET]);
    end

    assign trig.level = flags_reg[gad_pkg::FL_FGET];
    assign trig.clr = fget_clr_reg;

    gad_trig_stretch u_trig (
        .ref_clk_in(ref_clk_in),
        .arst_n_in(arst_n_in),
        .trig(trig)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign avs_readdata_out = rdata_reg;
    assign avs_waitrequest_out = wait_reg;
    assign feature_flags_out = flags_reg;
    assign cmd_pulse_out = pulse_reg;
    assign iface_idle_out = flags_reg[gad_pkg::FL_SWRST];
    assign bus_present_out = present_reg;
    assign rfd_holdoff_out = rfd_reg;
    assign dac_holdoff_out = dac_reg;
    assign secondary_valid_out = sec_valid_reg;
    assign secondary_invalid_out = sec_invalid_reg;
    assign rtl_message_out = rtl_msg_reg;
    assign interrupt_disable_out = flags_reg[gad_pkg::FL_DAI];
    assign trigger_output_pin_out = trig.pin;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    pulse_one_a: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (pulse_reg != '0) |=> (pulse_reg == '0))
        else $error("command pulse lasted more than one cycle");

    flag_hold_a: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        !aux_acc |=> $stable(flags_reg))
        else $error("feature flag changed without a command");

    gap_space_a: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        wr_acc |=> !wr_acc [*3])
        else $error("writes accepted closer than four cycles");

    swrst_set_a: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (chip_rst || swrst_cmd) |=> flags_reg[gad_pkg::FL_SWRST]
            ##1 !bus_present_out)
        else $error("software reset not set by command");

    present_a: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        bus_present_out != $past(flags_reg[gad_pkg::FL_SWRST]))
        else $error("presence does not follow software reset");

    dac_rel_a: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (rel_dac && !dac_holdoff_req_in) |=> !dac_holdoff_out)
        else $error("command holdoff not released");

    sec_valid_a: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (address_pass_through_in && aux_hit(aux_acc, cmd,
            gad_pkg::PULSE_CODE[gad_pkg::P_VALID]))
        |=> secondary_valid_out && !secondary_invalid_out
            ##1 !secondary_valid_out)
        else $error("valid secondary mark missing or too long");

    rfd_hold_a: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (byte_received_in && flags_reg[gad_pkg::FL_HDFA] &&
         !flags_reg[gad_pkg::FL_SWRST]) |=> rfd_holdoff_out)
        else $error("ready holdoff not taken after data byte");

    chrst_clear_a: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        chip_rst |=> !flags_reg[gad_pkg::FL_HDFA] &&
            !flags_reg[gad_pkg::FL_HDFE] && !rtl_message_out)
        else $error("chip reset left holdoff flags set");

    reserved_a: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (aux_acc && (cmd & gad_pkg::RSVD_BIT_MASK) != 8'h00)
        |=> $stable(flags_reg) && (pulse_reg == '0))
        else $error("reserved code had an effect");

    read_ans_a: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (avs_read_in && avs_waitrequest_out) |=> !avs_waitrequest_out)
        else $error("read not answered in one cycle");

endmodule

/* logic/gad_pkg.sv */
// Purpose: shared constants for the auxiliary command decoder
// Assumes: Avalon-MM slave with byte addresses, 32-bit data
// Notes: codes listed by flag or pulse index, see the arrays below
package gad_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_AUX_CMD = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [31:0] READ_ZERO = 32'h0;
    localparam int ST_RFD_HOLD = 16;
    localparam int ST_DAC_HOLD = 17;
    localparam int ST_TRIG_PIN = 18;

    // ------------------------------------------------------------
    // static feature flags
    // ------------------------------------------------------------
    localparam int NUM_FLAGS = 16;
    localparam int FL_SWRST = 0;
    localparam int FL_HDFA = 1;
    localparam int FL_HDFE = 2;
    localparam int FL_FGET = 3;
    localparam int FL_RTL = 4;
    localparam int FL_LON = 5;
    localparam int FL_TON = 6;
    localparam int FL_RPP = 7;
    localparam int FL_SIC = 8;
    localparam int FL_SRE = 9;
    localparam int FL_DAI = 10;
    localparam int FL_STDL = 11;
    localparam int FL_SHDW = 12;
    localparam int FL_VSTDL = 13;
    localparam int FL_SERVICE_REQUEST_SECOND = 14;
    localparam int FL_IST = 15;
    // software reset comes up set, every other feature clear
    localparam logic [NUM_FLAGS-1:0] FLAGS_RESET = 16'h0001;
    localparam logic [7:0] SET_BIT_MASK = 8'h80;
    localparam logic [7:0] RSVD_BIT_MASK = 8'h60;
    // clear code per flag; the set code adds SET_BIT_MASK
    localparam logic [7:0] FLAG_CLR_CODE [NUM_FLAGS] = '{
        8'h00, 8'h03, 8'h04, 8'h06, 8'h07, 8'h09, 8'h0a, 8'h0e,
        8'h0f, 8'h10, 8'h13, 8'h15, 8'h16, 8'h17, 8'h18, 8'h1d
    };

    // ------------------------------------------------------------
    // pulsed commands
    // ------------------------------------------------------------
    localparam int NUM_PULSES = 20;
    localparam int P_NONVALID = 0;
    localparam int P_VALID = 1;
    localparam int P_RHDF = 2;
    localparam int P_NBAF = 3;
    localparam int P_FEOI = 4;
    localparam int P_GTS = 5;
    localparam int P_TCA = 6;
    localparam int P_TCS = 7;
    localparam int P_RQC = 8;
    localparam int P_RLC = 9;
    localparam int P_PTS = 10;
    localparam int P_SWITCH_COMPAT = 11;
    localparam int P_REQF = 12;
    localparam int P_REQT = 13;
    localparam int P_CHRST = 14;
    localparam int P_PI_MASK3 = 15;
    localparam int P_PI_BUSCTL = 16;
    localparam int P_CLRPI = 17;
    localparam int P_PI_EOS = 18;
    localparam int P_PI_ACC = 19;
    localparam logic [7:0] PULSE_CODE [NUM_PULSES] = '{
        8'h01, 8'h81, 8'h02, 8'h05, 8'h08, 8'h0b, 8'h0c, 8'h0d,
        8'h11, 8'h12, 8'h14, 8'h99, 8'h1a, 8'h9a, 8'h1c, 8'h1e,
        8'h1f, 8'h9c, 8'h9e, 8'h9f
    };

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int GAP_CYCLES = 4;
    localparam logic [2:0] GAP_LOAD = 3'(GAP_CYCLES - 2);
    localparam int TRIG_MIN_CYCLES = 5;
    localparam int TRIG_CNT_W = 3;
    localparam logic [TRIG_CNT_W-1:0] TRIG_LOAD =
        TRIG_CNT_W'(TRIG_MIN_CYCLES - 1);

endpackage

/* logic/gad_trig_if.sv */
// Purpose: carrier between decoder and trigger pin stretcher
// Assumes: single clock domain
// Notes: level is the held trigger flag, clr a one-cycle pulse
interface gad_trig_if;
    logic level;
    logic clr;
    logic pin;
    modport ctrl (output level, output clr, input pin);
    modport stretch (input level, input clr, output pin);
endinterface

/* logic/gad_trig_stretch.sv */
// Purpose: drive the trigger pin from the held flag and clear pulse
// Assumes: clr lasts one cycle, level already dropped when clr comes
// Notes: pin comes straight from a flip-flop
module gad_trig_stretch (
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    gad_trig_if.stretch trig
);

    logic [gad_pkg::TRIG_CNT_W-1:0] cnt_reg;

    // ------------------------------------------------------------
    // minimum pulse counter
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            cnt_reg <= '0;
        else if (trig.clr)
            cnt_reg <= gad_pkg::TRIG_LOAD;
        else if (cnt_reg != '0)
            cnt_reg <= cnt_reg - 1'b1;
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            trig.pin <= 1'b0;
        else
            trig.pin <= trig.level | trig.clr | (cnt_reg != '0);
    end

    trig_pulse_a: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        trig.clr |=> trig.pin [*5])
        else $error("trigger pin pulse shorter than five cycles");

endmodule

/* bench/gad_host_model.sv */
// Purpose: host model issuing bus cycles to the command port
// Assumes: one clock, Avalon-MM master waiting out waitrequest
// Notes: a wait that runs out returns ok low to the caller
module gad_host_model (
    input wire logic clk_in,
    input wire logic waitreq_in,
    input wire logic [31:0] rdata_in,
    output logic [3:0] addr_out,
    output logic rd_out,
    output logic wr_out,
    output logic [31:0] wdata_out,
    output logic [3:0] be_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        addr_out = 4'h0;
        rd_out = 1'b0;
        wr_out = 1'b0;
        wdata_out = 32'h0;
        be_out = 4'h0;
    end
    // ------------------------------------------------------------
    // one task for both directions keeps the handshake in one place
    // ------------------------------------------------------------
    task automatic xfer(input logic w, input logic [3:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output bit ok);
        int n;
        @(posedge clk_in);
        addr_out <= a;
        wdata_out <= d;
        be_out <= 4'hf;
        wr_out <= w;
        rd_out <= !w;
        n = 0;
        // stalls that space writes are waited out, never cut short;
        // waitrequest is judged at the rising edge that takes the request
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (waitreq_in !== 1'b0 && n < 200);
        ok = (waitreq_in === 1'b0);
        q = rdata_in;
        wr_out <= 1'b0;
        rd_out <= 1'b0;
        // released data must not look like the last value
        wdata_out <= ~d;
    endtask
endmodule

/* bench/tb.sv */
// Purpose: self-checking bench for the auxiliary command decoder
// Assumes: host model drives the bus, bench drives the bus events
// Notes: one task per scenario, each judges its own results
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic rx = 1'b0;
    logic eoi = 1'b0;
    logic dreq = 1'b0;
    logic address_pass_through = 1'b0;
    logic [3:0] addr, be;
    logic rd, wr, waitreq;
    logic [31:0] wdata, rdata;
    logic [15:0] flags;
    logic [19:0] pulse;
    logic idle, present, rfd, dac, sec_v, sec_i, rtl, dai, trig;
    int n_fail = 0;
    int checked = 0;
    always #5 clk = ~clk;
    gad_host_model gad_host_model_i (.clk_in(clk), .waitreq_in(waitreq),
        .rdata_in(rdata), .addr_out(addr), .rd_out(rd), .wr_out(wr),
        .wdata_out(wdata), .be_out(be));
    gad_aux_cmd_decoder gad_aux_cmd_decoder_i (.ref_clk_in(clk),
        .arst_n_in(rst_n), .avs_address_in(addr), .avs_read_in(rd),
        .avs_write_in(wr), .avs_writedata_in(wdata),
        .avs_byteenable_in(be), .avs_readdata_out(rdata),
        .avs_waitrequest_out(waitreq), .byte_received_in(rx),
        .end_condition_in(eoi), .dac_holdoff_req_in(dreq),
        .address_pass_through_in(address_pass_through), .feature_flags_out(flags),
        .cmd_pulse_out(pulse), .iface_idle_out(idle),
        .bus_present_out(present), .rfd_holdoff_out(rfd),
        .dac_holdoff_out(dac), .secondary_valid_out(sec_v),
        .secondary_invalid_out(sec_i), .rtl_message_out(rtl),
        .interrupt_disable_out(dai), .trigger_output_pin_out(trig));
    // ------------------------------------------------------------
    // checking and bus helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, exp, input string m);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error at %0t: %s", $time, m);
        end
    endtask
    task automatic tally_and_finish();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [7:0] c, output logic [31:0] q);
        bit ok;
        gad_host_model_i.xfer(w, a, {24'h0, c}, q, ok);
        if (!ok)
        begin
            n_fail++;
            $display("Error at %0t: bus wait ran out", $time);
            tally_and_finish();
        end
    endtask
    // returns at the negedge right after the accepting edge
    task automatic cmd(input logic [7:0] c);
        logic [31:0] q;
        bus(1'b1, gad_pkg::OFS_AUX_CMD, c, q);
        @(negedge clk);
    endtask
    task automatic rx_byte(input logic e);
        @(posedge clk);
        rx <= 1'b1;
        eoi <= e;
        @(posedge clk);
        rx <= 1'b0;
        repeat (2) @(negedge clk);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        logic [31:0] q;
        chk(flags, 16'h0001, "flags after reset");
        chk(idle, 1'b1, "idle after reset");
        chk(present, 1'b0, "present in soft reset");
        bus(1'b0, gad_pkg::OFS_STATUS, 8'h0, q);
        chk(q, 32'h1, "status after reset");
        bus(1'b0, 4'h8, 8'h0, q);
        chk(q, gad_pkg::READ_ZERO, "unmapped read");
        $display("test reset done");
    endtask
    task automatic t_flags();
        logic [7:0] c;
        cmd(8'h00);
        @(negedge clk);
        chk(present, 1'b1, "present after clear");
        chk(idle, 1'b0, "idle after clear");
        for (int i = 1; i < gad_pkg::NUM_FLAGS; i++)
        begin
            c = gad_pkg::FLAG_CLR_CODE[i];
            cmd(c | gad_pkg::SET_BIT_MASK);
            repeat (3) @(negedge clk);
            chk(flags, 16'h1 << i, "flag set");
            chk(dai, i == gad_pkg::FL_DAI, "irq disable");
            chk(rtl, i == gad_pkg::FL_RTL, "rtl level");
            cmd(c);
            chk(flags, 16'h0, "flag clear");
        end
        $display("test flags done");
    endtask
    task automatic t_pulses();
        @(posedge clk);
        address_pass_through <= 1'b1;
        for (int i = 0; i < gad_pkg::NUM_PULSES; i++)
        begin
            cmd(gad_pkg::PULSE_CODE[i]);
            chk(pulse, 20'h1 << i, "pulse high");
            chk(sec_v, i == gad_pkg::P_VALID, "valid mark");
            chk(sec_i, i == gad_pkg::P_NONVALID, "invalid mark");
            @(negedge clk);
            chk(pulse, 20'h0, "pulse one cycle");
        end
        @(posedge clk);
        address_pass_through <= 1'b0;
        $display("test pulses done");
    endtask
    task automatic t_hold();
        logic [31:0] q;
        cmd(8'h00);
        cmd(8'h83);
        rx_byte(1'b0);
        chk(rfd, 1'b1, "hold on all data");
        bus(1'b0, gad_pkg::OFS_STATUS, 8'h0, q);
        chk(q[gad_pkg::ST_RFD_HOLD], 1'b1, "status hold bit");
        cmd(8'h02);
        @(negedge clk);
        chk(rfd, 1'b0, "ready released");
        cmd(8'h03);
        cmd(8'h84);
        rx_byte(1'b0);
        chk(rfd, 1'b0, "no hold without end");
        rx_byte(1'b1);
        chk(rfd, 1'b1, "hold on end");
        cmd(8'h02);
        cmd(8'h04);
        @(posedge clk);
        dreq <= 1'b1;
        @(posedge clk);
        dreq <= 1'b0;
        repeat (2) @(negedge clk);
        chk(dac, 1'b1, "command holdoff");
        bus(1'b0, gad_pkg::OFS_STATUS, 8'h0, q);
        chk(q[gad_pkg::ST_DAC_HOLD], 1'b1, "status holdoff bit");
        cmd(8'h01);
        @(negedge clk);
        chk(dac, 1'b0, "command holdoff released");
        $display("test holdoff done");
    endtask
    task automatic t_trig();
        int cnt;
        logic [31:0] q;
        cnt = 0;
        cmd(8'h06);
        repeat (8)
        begin
            if (trig === 1'b1)
                cnt++;
            @(negedge clk);
        end
        chk(cnt >= 5, 1'b1, "trigger pulse length");
        cmd(8'h86);
        repeat (20) @(negedge clk);
        chk(trig, 1'b1, "trigger held");
        bus(1'b0, gad_pkg::OFS_STATUS, 8'h0, q);
        chk(q[gad_pkg::ST_TRIG_PIN], 1'b1, "status trigger bit");
        cmd(8'h06);
        repeat (12) @(negedge clk);
        chk(trig, 1'b0, "trigger dropped");
        $display("test trigger done");
    endtask
    task automatic t_rsvd();
        logic [7:0] codes [4] = '{8'h1b, 8'he0, 8'ha3, 8'h3c};
        logic [31:0] q;
        bus(1'b1, gad_pkg::OFS_STATUS, 8'h80, q);
        for (int i = 0; i < 4; i++)
        begin
            cmd(codes[i]);
            chk(pulse, 20'h0, "no pulse");
            @(negedge clk);
            chk(flags, 16'h0, "no flag change");
        end
        $display("test reserved done");
    endtask
    task automatic t_chrst();
        logic [31:0] q;
        cmd(8'h83);
        cmd(8'h87);
        cmd(8'h1c);
        chk(flags, 16'h0001, "chip reset flags");
        @(negedge clk);
        chk(present, 1'b0, "absent after chip reset");
        cmd(8'h00);
        cmd(8'h89);
        cmd(8'h80);
        chk(flags, 16'h0001, "soft reset set, listen only off");
        cmd(8'h00);
        cmd(8'h83);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(negedge clk);
        chk(flags, 16'h0001, "flags in hard reset");
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(negedge clk);
        chk(present, 1'b0, "absent after hard reset");
        bus(1'b0, gad_pkg::OFS_STATUS, 8'h0, q);
        chk(q, 32'h1, "status after hard reset");
        $display("test chip reset done");
    endtask
    initial
    begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_flags();
        t_pulses();
        t_hold();
        t_trig();
        t_rsvd();
        t_chrst();
        tally_and_finish();
    end
endmodule
